/* File: core/lsap_cfg.svh */
`ifndef LSAP_CFG_SVH
`define LSAP_CFG_SVH

// Register offsets on the microprocessor port
`define LSAP_OFS_COMMAND 9'h022
`define LSAP_OFS_DATA 9'h023
`define LSAP_OFS_STATUS 9'h024
`define LSAP_OFS_CONFIG 9'h025

// Register reset values
`define LSAP_RST_COMMAND 8'h00
`define LSAP_RST_DATA 8'h00
`define LSAP_RST_CONFIG 8'h00

// Field positions
`define LSAP_BIT_DIR 0
`define LSAP_BIT_DONE 0
`define LSAP_BIT_IER 0
`define LSAP_BIT_CLK 6
`define LSAP_BIT_CS 7

// Serial frame: eight command bits then eight data bits
`define LSAP_FRAME_BITS 16
`define LSAP_CMD_BITS 8

// Shift clock rates and link reference clock, in Hz
`define LSAP_SCLK_SLOW_HZ 1024000
`define LSAP_SCLK_FAST_HZ 8192000
`define LSAP_LINK_HZ 16384000

// Half-period counts of the shift clock in link clock cycles
`define LSAP_HALF_SLOW \
  ((`LSAP_LINK_HZ / (2 * `LSAP_SCLK_SLOW_HZ)) < 1 ? 1 : \
   (`LSAP_LINK_HZ / (2 * `LSAP_SCLK_SLOW_HZ)))
`define LSAP_HALF_FAST \
  ((`LSAP_LINK_HZ / (2 * `LSAP_SCLK_FAST_HZ)) < 1 ? 1 : \
   (`LSAP_LINK_HZ / (2 * `LSAP_SCLK_FAST_HZ)))

`endif

/* File: core/lsap_pkg.sv */
package lsap_pkg;

  // Command register layout
  typedef struct packed {
    logic [6:0] remote_register_address;
    logic transfer_direction;
  } lsap_cmd_t;

  // Configuration register layout
  typedef struct packed {
    logic chip_select_choice;
    logic shift_clock_choice;
    logic [4:0] reserved;
    logic completion_irq_enable;
  } lsap_pcfg_t;

  // Microprocessor port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } lsap_mp_req_t;

  // Link-side sequencer
  typedef enum logic [0:0] {
    LSAP_IDLE = 1'b0,
    LSAP_SHIFT = 1'b1
  } lsap_state_t;

endpackage

/* File: core/lsap_top.sv */
`timescale 1ns/1ps
`include "lsap_cfg.svh"

// Operation
// - Command register write starts transfer
// - Write sends command then data, sixteen bits
// - Read sends command, receives eight data bits
// - Direction bit first, data LSB first
// - Command bit 0: 0 write, 1 read
// - Command bits 7..1 hold remote address
// - Completion flag low during transfer, set after
// - Completion with enable raises interrupt
// - Status read clears completion flag
// - Clearing flag withdraws interrupt request
// - Chip-select bit picks which select goes low
// - Clock bit picks 1.024 or 8.192 MHz
// - Config bit 0 enables completion interrupt
module lsap_top (
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Microprocessor port, synchronous to clk_sys_i
  input wire lsap_pkg::lsap_mp_req_t mp_req_i,
  output logic [7:0] mp_rdata_o,
  // Interrupt to host
  output logic host_irq_n_o,
  // Serial link, logic on the link reference clock
  input wire logic clk_link_i,
  input wire logic sdi_i,
  output logic sclk_o,
  output logic sdo_o,
  output logic remote_select_a_n_o,
  output logic remote_select_b_n_o
);
  import lsap_pkg::*;

  // A toggle that crossed two stages shows as a difference between the second and third stage
  function automatic logic toggled(input logic [2:0] sync);
    toggled = sync[2] ^ sync[1];
  endfunction

  // Data phase of a read: the line idles low and returned bits are taken.
  // Shared by the output mux and the sampler so both agree on the window.
  function automatic logic in_read_data(input logic rd,
    input logic [3:0] bit_idx);
    in_read_data = rd && (bit_idx >= 4'(`LSAP_CMD_BITS));
  endfunction

  // ---------------- System domain ----------------
  lsap_cmd_t cmd_q, cmd_d;
  logic [7:0] dat_q, dat_d;
  lsap_pcfg_t pcfg_q, pcfg_d;
  logic done_q, done_d;
  logic start_tog_q, start_tog_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_n_q, irq_n_d;
  logic [2:0] done_sync_q, done_sync_d;
  logic done_evt;
  // Returned byte, written only by the link side
  logic [7:0] rx_link_q;
  logic done_tog_q;

  // Completion toggle from the link side, two stages then edge detect.
  // A toggle rather than a pulse, so the slower clock never misses it.
  always_comb
  begin
    done_sync_d = {done_sync_q[1:0], done_tog_q};
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      done_sync_q <= 3'h0;
    else
      done_sync_q <= done_sync_d;
  end
  assign done_evt = toggled(done_sync_q);

  // Register file and completion flag.
  // Writes during a running frame are not guarded: the link side copies
  // command, data and config only when the start toggle arrives.
  always_comb
  begin
    cmd_d = cmd_q;
    dat_d = dat_q;
    pcfg_d = pcfg_q;
    done_d = done_q;
    start_tog_d = start_tog_q;
    rdata_d = 8'h00;
    if (mp_req_i.wr)
    begin
      unique case (mp_req_i.addr)
        `LSAP_OFS_COMMAND:
        begin
          cmd_d = lsap_cmd_t'(mp_req_i.wdata);
          start_tog_d = ~start_tog_q;
          done_d = 1'b0;
        end
        `LSAP_OFS_DATA: dat_d = mp_req_i.wdata;
        `LSAP_OFS_CONFIG: pcfg_d = lsap_pcfg_t'(mp_req_i.wdata);
        default: ;
      endcase
    end
    if (mp_req_i.rd)
    begin
      unique case (mp_req_i.addr)
        `LSAP_OFS_COMMAND: rdata_d = cmd_q;
        `LSAP_OFS_DATA: rdata_d = dat_q;
        `LSAP_OFS_STATUS:
        begin
          rdata_d = {7'h00, done_q};
          done_d = 1'b0;
        end
        `LSAP_OFS_CONFIG: rdata_d = pcfg_q;
        default: rdata_d = 8'h00;
      endcase
    end
    // Completion last, so a finishing transfer beats a status read
    if (done_evt)
    begin
      done_d = 1'b1;
      if (cmd_q.transfer_direction)
        dat_d = rx_link_q;
    end
    irq_n_d = ~(done_d & pcfg_d.completion_irq_enable);
  end

  // System state; done resets low so no stale interrupt follows reset
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_q <= lsap_cmd_t'(`LSAP_RST_COMMAND);
      dat_q <= `LSAP_RST_DATA;
      pcfg_q <= lsap_pcfg_t'(`LSAP_RST_CONFIG);
      done_q <= 1'b0;
      start_tog_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_n_q <= 1'b1;
    end
    else
    begin
      cmd_q <= cmd_d;
      dat_q <= dat_d;
      pcfg_q <= pcfg_d;
      done_q <= done_d;
      start_tog_q <= start_tog_d;
      rdata_q <= rdata_d;
      irq_n_q <= irq_n_d;
    end
  end

  // Host-facing outputs come straight from their flops
  assign mp_rdata_o = rdata_q;
  assign host_irq_n_o = irq_n_q;

  // ---------------- Link domain ----------------
  // The link clock free-runs; the device derives the shift clock from it.
  lsap_state_t state_q, state_d;
  // Input stages; the first stage is read by nothing but the second
  logic [2:0] start_sync_q, start_sync_d;
  logic [1:0] sdi_sync_q, sdi_sync_d;
  logic start_evt;
  logic [15:0] tx_q, tx_d;
  logic [7:0] rx_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] half_q, half_d;
  logic [7:0] hcnt_q, hcnt_d;
  logic rd_q, rd_d;
  logic sclk_q, sclk_d;
  logic sdo_q, sdo_d;
  logic sel_a_n_q, sel_a_n_d;
  logic sel_b_n_q, sel_b_n_d;
  logic done_tog_d;
  // Sample and frame-end strobes, one link cycle each
  logic samp_q, samp_d;
  logic fin_q, fin_d;

  // Start toggle and serial input each pass two stages first
  always_comb
  begin
    start_sync_d = {start_sync_q[1:0], start_tog_q};
    sdi_sync_d = {sdi_sync_q[0], sdi_i};
  end

  always_ff @(posedge clk_link_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_sync_q <= 3'h0;
      sdi_sync_q <= 2'h0;
    end
    else
    begin
      start_sync_q <= start_sync_d;
      sdi_sync_q <= sdi_sync_d;
    end
  end
  assign start_evt = toggled(start_sync_q);

  // Shift sequencer. Host registers are quasi-static during a frame,
  // so they are sampled once at the start event without a bus.
  // At the fast rate a half period may be a single link cycle, so every
  // step below is one cycle long.
  always_comb
  begin
    state_d = state_q;
    tx_d = tx_q;
    rx_d = rx_link_q;
    bit_d = bit_q;
    half_d = half_q;
    hcnt_d = hcnt_q;
    rd_d = rd_q;
    sclk_d = sclk_q;
    sdo_d = sdo_q;
    sel_a_n_d = sel_a_n_q;
    sel_b_n_d = sel_b_n_q;
    done_tog_d = done_tog_q;
    samp_d = 1'b0;
    fin_d = 1'b0;
    // Returned bits enter at the top
    // One cycle after a fall the input stages still hold the bit set on the fall before
    if (samp_q)
      rx_d = {sdi_sync_q[1], rx_link_q[7:1]};
    // Completion after last sample
    // The toggle moves with the last sample, so the byte is settled first
    if (fin_q)
      done_tog_d = ~done_tog_q;
    unique case (state_q)
      LSAP_IDLE:
      begin
        if (start_evt)
        begin
          tx_d = {dat_q, cmd_q};
          rd_d = cmd_q.transfer_direction;
          half_d = pcfg_q.shift_clock_choice ?
                   8'(`LSAP_HALF_FAST) : 8'(`LSAP_HALF_SLOW);
          hcnt_d = 8'h01;
          bit_d = 4'h0;
          sdo_d = cmd_q.transfer_direction;
          sclk_d = 1'b0;
          sel_a_n_d = pcfg_q.chip_select_choice;
          sel_b_n_d = ~pcfg_q.chip_select_choice;
          state_d = LSAP_SHIFT;
        end
      end
      LSAP_SHIFT:
      begin
        if (hcnt_q != half_q)
          hcnt_d = hcnt_q + 8'h01;
        else
        begin
          hcnt_d = 8'h01;
          sclk_d = ~sclk_q;
          // Rising edges only flip the clock; every bit moves on a fall
          if (sclk_q)
          begin
            // Returned bit taken next cycle
            // The remote changes its line on this fall and the input has
            // two stages of delay, so a sample at the next rise would see
            // a stale bit once the half period is one cycle.
            samp_d = in_read_data(rd_q, bit_q);
            if (bit_q == 4'(`LSAP_FRAME_BITS - 1))
            begin
              sel_a_n_d = 1'b1;
              sel_b_n_d = 1'b1;
              sdo_d = 1'b0;
              fin_d = 1'b1;
              state_d = LSAP_IDLE;
            end
            else
            begin
              bit_d = bit_q + 4'h1;
              tx_d = {1'b0, tx_q[15:1]};
              sdo_d = in_read_data(rd_q, bit_d) ? 1'b0 : tx_q[1];
            end
          end
        end
      end
    endcase
  end

  // Link state; reset leaves the selects high and the shift clock low
  always_ff @(posedge clk_link_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= LSAP_IDLE;
      tx_q <= 16'h0000;
      rx_link_q <= 8'h00;
      bit_q <= 4'h0;
      half_q <= 8'h01;
      hcnt_q <= 8'h01;
      rd_q <= 1'b0;
      sclk_q <= 1'b0;
      sdo_q <= 1'b0;
      sel_a_n_q <= 1'b1;
      sel_b_n_q <= 1'b1;
      done_tog_q <= 1'b0;
      samp_q <= 1'b0;
      fin_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tx_q <= tx_d;
      rx_link_q <= rx_d;
      bit_q <= bit_d;
      half_q <= half_d;
      hcnt_q <= hcnt_d;
      rd_q <= rd_d;
      sclk_q <= sclk_d;
      sdo_q <= sdo_d;
      sel_a_n_q <= sel_a_n_d;
      sel_b_n_q <= sel_b_n_d;
      done_tog_q <= done_tog_d;
      samp_q <= samp_d;
      fin_q <= fin_d;
    end
  end

  // Pins straight from link-domain flops
  assign sclk_o = sclk_q;
  assign sdo_o = sdo_q;
  assign remote_select_a_n_o = sel_a_n_q;
  assign remote_select_b_n_o = sel_b_n_q;

endmodule

/* File: verification/lsap_liu_model.sv */
`timescale 1ns/1ps
module lsap_liu_model (
  // Link pins
  input wire logic sclk_i,
  input wire logic sel_a_n_i,
  input wire logic sel_b_n_i,
  input wire logic sdo_i,
  output logic sdi_o,
  // Bench side
  input wire logic [7:0] rdata_i,
  output logic [15:0] frame_o,
  output logic bsel_o
);
  logic [4:0] bits;
  wire idle = sel_a_n_i & sel_b_n_i;
  // Known values before the first frame
  initial
  begin
    sdi_o = 1'b0;
    bits = 5'h00;
    frame_o = 16'h0000;
    bsel_o = 1'b0;
  end
  // A new frame restarts the bit count
  always @(negedge idle) bits = 5'h00;
  always @(posedge sclk_i)
    if (!idle)
    begin
      frame_o[bits[3:0]] <= sdo_i;
      bsel_o <= sel_a_n_i;
      bits <= bits + 5'h01;
    end
  // answer LSB first
  // Undriven times show a changing level, so a lucky 0 or 1 never passes
  always @(negedge sclk_i or posedge idle)
    sdi_o <= (!idle && frame_o[0] && bits[3]) ? rdata_i[bits[2:0]] : ~sdi_o;
endmodule

/* File: verification/lsap_chk.sv */
`timescale 1ns/1ps
`include "lsap_cfg.svh"
module lsap_chk (
  // Clocks and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_link_i,
  // Host side
  input wire lsap_pkg::lsap_mp_req_t mp_req_i,
  input wire logic [7:0] mp_rdata_o,
  input wire logic host_irq_n_o,
  // Link side
  input wire logic sdi_i,
  input wire logic sclk_o,
  input wire logic sdo_o,
  input wire logic remote_select_a_n_o,
  input wire logic remote_select_b_n_o
);
  import lsap_pkg::*;
  logic idle;
  // Both selects high means no frame
  assign idle = remote_select_a_n_o & remote_select_b_n_o;
  sequence s_stat_rd;
    mp_req_i.rd && mp_req_i.addr == `LSAP_OFS_STATUS;
  endsequence
  sequence s_cmd_wr;
    mp_req_i.wr && mp_req_i.addr == `LSAP_OFS_COMMAND;
  endsequence
  AST_SEL_ONE: assert property (@(posedge clk_link_i) disable iff (rst_i)
    remote_select_a_n_o | remote_select_b_n_o) else $error("both selects low");
  AST_SCLK_IDLE: assert property (@(posedge clk_link_i) disable iff (rst_i)
    idle |-> !sclk_o) else $error("shift clock outside frame");
  AST_STAT_FMT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_stat_rd |=> mp_rdata_o[7:1] == 7'h00) else $error("status bits set");
  AST_STAT_CLR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_stat_rd |=> host_irq_n_o) else $error("irq kept after status read");
  AST_CMD_BUSY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_cmd_wr |=> host_irq_n_o [*2]) else $error("irq during transfer");
  AST_IRQ_DONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!host_irq_n_o and s_stat_rd) |=> mp_rdata_o[0])
    else $error("irq without done");
  AST_BUSY_IRQ: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !idle |-> host_irq_n_o) else $error("irq while frame runs");
  AST_SEL_START: assert property (@(posedge clk_link_i) disable iff (rst_i)
    $fell(idle) |-> !sclk_o ##1 !idle) else $error("frame start broken");
endmodule
bind lsap_top lsap_chk lsap_chk_i (.clk_sys_i, .rst_i, .clk_link_i,
  .mp_req_i, .mp_rdata_o, .host_irq_n_o, .sdi_i, .sclk_o, .sdo_o,
  .remote_select_a_n_o, .remote_select_b_n_o);

/* File: verification/lsap_top_tb.sv */
`timescale 1ns/1ps
`include "lsap_cfg.svh"
module lsap_top_tb;
  import lsap_pkg::*;
  logic clk_sys_i, clk_link_i, rst_i, sdi, irq_n, sclk, sdo, sa_n, sb_n;
  logic bsel, pend;
  lsap_mp_req_t req;
  logic [7:0] rdata, rbyte;
  logic [15:0] frame;
  logic [31:0] lfsr = 32'h174584b7;
  logic [7:0] exp_q[$];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  realtime t0;
  lsap_top lsap_top_i (.clk_sys_i, .rst_i, .mp_req_i(req),
    .mp_rdata_o(rdata), .host_irq_n_o(irq_n), .clk_link_i, .sdi_i(sdi),
    .sclk_o(sclk), .sdo_o(sdo), .remote_select_a_n_o(sa_n),
    .remote_select_b_n_o(sb_n));
  lsap_liu_model lsap_liu_model_i (.sclk_i(sclk), .sel_a_n_i(sa_n),
    .sel_b_n_i(sb_n), .sdo_i(sdo), .sdi_o(sdi), .rdata_i(rbyte),
    .frame_o(frame), .bsel_o(bsel));
  // Clocks, link clock offset so the phases never line up
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    clk_link_i = 1'b0;
    #7;
    forever #24 clk_link_i = ~clk_link_i;
  end
  task automatic chk(input string n, input [31:0] e, input [31:0] s);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      report_and_stop;
    end
  end
  // Read data is valid the cycle after the taken read
  always @(posedge clk_sys_i) pend <= req.rd;
  always @(negedge clk_sys_i)
    if (pend)
      chk("mp_rdata_o", exp_q.pop_front(), rdata);
  // One register access; for reads d is the expected value
  task automatic acc(input logic w, input [8:0] a, input [7:0] d);
    @(negedge clk_sys_i);
    req = '{w, !w, a, d};
    if (!w)
      exp_q.push_back(d);
    @(negedge clk_sys_i);
    req = '0;
  endtask
  // Next state of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One transfer: i[0] picks select, i[1] the fast clock,
  // their parity the direction, so both rates see reads and writes
  task automatic run(input logic [1:0] i);
    logic [7:0] cfg, cmd, d;
    lfsr = lfsr_next(lfsr);
    cfg = {i[0], i[1], 5'h00, ~i[0]};
    cmd = {lfsr[6:0], ^i};
    d = lfsr[15:8];
    rbyte = lfsr[23:16];
    acc(1'b1, `LSAP_OFS_CONFIG, cfg);
    acc(1'b1, `LSAP_OFS_DATA, d);
    acc(1'b1, `LSAP_OFS_COMMAND, cmd);
    wait (!(sa_n & sb_n));
    t0 = $realtime;
    wait (sa_n & sb_n);
    chk("frame_ns", 32 * 48 * (i[1] ? `LSAP_HALF_FAST : `LSAP_HALF_SLOW),
      int'($realtime - t0));
    chk("cmd_bits", cmd, frame[7:0]);
    if (!cmd[0])
      chk("data_bits", d, frame[15:8]);
    chk("select_b", i[0], bsel);
    // wait for completion before the next access
    repeat (6) @(negedge clk_sys_i);
    chk("irq_n", !cfg[0], irq_n);
    acc(1'b0, `LSAP_OFS_STATUS, 8'h01);
    acc(1'b0, `LSAP_OFS_STATUS, 8'h00);
    chk("irq_n", 1, irq_n);
    acc(1'b0, `LSAP_OFS_DATA, cmd[0] ? rbyte : d);
    acc(1'b0, `LSAP_OFS_CONFIG, cfg);
    acc(1'b0, `LSAP_OFS_COMMAND, cmd);
  endtask
  // Reset, reset values, an unmapped read, then all select and clock modes
  initial
  begin
    req = '0;
    rbyte = 8'h00;
    rst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (int a = 'h22; a < 'h26; a++)
      acc(1'b0, a[8:0], 8'h00);
    acc(1'b0, 9'h026, 8'h00);
    for (int i = 0; i < 4; i++)
      run(i[1:0]);
    repeat (3) @(negedge clk_sys_i);
    report_and_stop;
  end
endmodule
